/* reset_sync_pwm_timer_setup_test.sv */
// Self-checking testbench of the PWM timer setup block.
`timescale 1ns/10ps
`default_nettype none
module reset_sync_pwm_timer_setup_test;
	import rspwm_pkg::*;
	logic         clk_sys_i        = 1'b0;
	logic         rst_n_i          = 1'b0;
	logic [7:0]   avs_address_i    = 8'h00;
	logic         avs_read_i       = 1'b0;
	logic         avs_write_i      = 1'b0;
	logic [31:0]  avs_writedata_i  = 32'h0;
	logic [3:0]   avs_byteenable_i = 4'hf;
	rspwm_ev_t    events_i         = '0;
	logic [1:0]   pwm_wave_i       = 2'h0;
	logic         cutoff_req_i     = 1'b0;
	logic [31:0]  avs_readdata_o;
	logic         avs_waitrequest_o;
	logic         irq_o;
	logic         lockstep_o;
	logic [1:0]   irq_level_o;
	logic [1:0]   comb_mode_o;
	logic [1:0]   pad;
	logic [1:0]   flt;
	rspwm_phase_t phase_o;
	rspwm_cmp_t   cnt0_cmp_o;
	rspwm_cmp_t   cnt1_cmp_o;
	rspwm_pin_t   ch0_pin_a_o;
	rspwm_pin_t   ch0_pin_b_o;
	int           fails       = 0;
	int           check_count = 0;
	integer       seed        = 32'hb097;
	logic [31:0]  exp_q[$];
	logic [15:0]  m[2][4];
	logic [31:0]  v;
	logic [31:0]  lv;
	logic [1:0]   cd;
	logic         en;
	int           b;
	int           c;
	int           i;
	int           k;
	int           j;

	rspwm_setup i_rspwm_setup (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .events_i(events_i),
		.pwm_wave_i(pwm_wave_i), .cutoff_req_i(cutoff_req_i),
		.irq_o(irq_o), .irq_level_o(irq_level_o), .lockstep_o(lockstep_o),
		.comb_mode_o(comb_mode_o), .phase_o(phase_o),
		.cnt0_cmp_o(cnt0_cmp_o), .cnt1_cmp_o(cnt1_cmp_o),
		.ch0_pin_a_o(ch0_pin_a_o), .ch0_pin_b_o(ch0_pin_b_o)
	);

	rspwm_stage i_rspwm_stage (
		.clk_sys_i(clk_sys_i), .pin_a_i(ch0_pin_a_o),
		.pin_b_i(ch0_pin_b_o), .pad_o(pad), .float_o(flt)
	);

	// Free-running system clock.
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input string what, input logic [31:0] seen,
	                     input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Outputs are looked at on the falling edge, once they have settled.
	task automatic settle();
		@(negedge clk_sys_i);
	endtask

	// One access; an extra edge after release keeps two requests apart.
	task automatic bus(input logic rd, input logic [7:0] adr,
	                   input logic [31:0] wd);
		@(posedge clk_sys_i);
		avs_address_i   <= adr;
		avs_read_i      <= rd;
		avs_write_i     <= ~rd;
		avs_writedata_i <= wd;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		bus(1'b0, adr, wd);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b1, adr, 32'h0);
	endtask

	task automatic pulse(input rspwm_ev_t ev);
		@(posedge clk_sys_i);
		events_i <= ev;
		@(posedge clk_sys_i);
		events_i <= '0;
		@(posedge clk_sys_i);
	endtask

	task automatic wait2();
		repeat (2) @(posedge clk_sys_i);
	endtask

	function automatic logic [7:0] ca(input int cn, input int ix);
		return 8'(32'h20 + 16 * cn + 4 * ix);
	endfunction

	// Read data is matched against the oldest note at the completing edge.
	always @(posedge clk_sys_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) begin
			check("readdata", avs_readdata_o, exp_q.pop_front());
		end
	end

	// Whatever hangs, the run still ends with a verdict.
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		stop_test();
	end

	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(OFS_IRQ_MASK, 32'hff);
		rd(OFS_PRIO_HI, 32'hff);
		settle();
		check("irq_level", irq_level_o, 32'h3);
		wr(OFS_MODE, 32'hf1);
		rd(OFS_MODE, 32'h0);
		wr(OFS_CLK_EN, 32'h1);
		wr(OFS_MODE, 32'hf1);
		rd(OFS_MODE, 32'hf1);
		settle();
		check("lockstep", lockstep_o, 32'h1);
		wr(OFS_MODE, 32'h0);
		settle();
		check("lockstep", lockstep_o, 32'h0);
		wr(8'h40, 32'h5a);
		rd(8'h40, 32'h0);
		// Each buffer select alone; both counters see their match event.
		for (b = 4; b < 8; b++) begin
			wr(OFS_MODE, 32'h0);
			for (c = 0; c < 8; c++) begin
				m[c / 4][c % 4] = 16'($random(seed));
				wr(ca(c / 4, c % 4), {16'h0, m[c / 4][c % 4]});
			end
			wr(OFS_MODE, 32'h1 << b);
			pulse('{cnt0_match_a: 1'b1, cnt1_match_a: 1'b1, default: 1'b0});
			c = (b >= 6) ? 1 : 0;
			m[c][b % 2] = m[c][2 + b % 2];
			for (i = 0; i < 8; i++) begin
				rd(ca(i / 4, i % 4), {16'h0, m[i / 4][i % 4]});
			end
			settle();
			check("cnt0_a", cnt0_cmp_o.a, m[0][0]);
			check("cnt0_b", cnt0_cmp_o.b, m[0][1]);
			check("cnt1_a", cnt1_cmp_o.a, m[1][0]);
			check("cnt1_b", cnt1_cmp_o.b, m[1][1]);
		end
		// Every combination code, with random output level bits.
		wr(OFS_MODE, 32'h10);
		for (k = 0; k < 4; k++) begin
			lv = $random(seed) & 32'hc;
			en = (k != 0);
			wr(OFS_FUNC_CTRL, lv | k);
			settle();
			check("comb_mode", comb_mode_o, k);
			check("phase", phase_o, {en, en & lv[2], en & lv[3]});
			v = {16'h0, 16'($random(seed))};
			wr(ca(0, 2), v);
			pulse('{cnt0_match_a: 1'b1, default: 1'b0});
			if (k != 2) m[0][0] = v[15:0];
			rd(ca(0, 0), {16'h0, m[0][0]});
			pulse('{cnt1_underflow: 1'b1, default: 1'b0});
			m[0][0] = v[15:0];
			rd(ca(0, 0), {16'h0, m[0][0]});
		end
		// Request while masked, then priority codes and unmasking.
		pulse('{ch0_timer_interrupt: 1'b1, default: 1'b0});
		wait2();
		check("irq", irq_o, 32'h0);
		rd(OFS_IRQ_REQ, 32'h2);
		rd(OFS_IRQ_REQ, 32'h0);
		pulse('{ch0_timer_interrupt: 1'b1, default: 1'b0});
		for (k = 0; k < 4; k++) begin
			wr(OFS_PRIO_LO, 32'(k % 2) << 1);
			wr(OFS_PRIO_HI, 32'(k / 2) << 1);
			settle();
			check("irq_level", irq_level_o, k);
		end
		wr(OFS_IRQ_MASK, 32'hfd);
		wait2();
		check("irq", irq_o, 32'h1);
		wr(OFS_IRQ_MASK, 32'hff);
		wait2();
		check("irq", irq_o, 32'h0);
		wr(OFS_IRQ_MASK, 32'hfd);
		wr(OFS_IRQ_REQ, 32'h0);
		wait2();
		check("irq", irq_o, 32'h0);
		// All cutoff codes of both pins under a held cutoff request.
		cutoff_req_i <= 1'b1;
		for (k = 0; k < 16; k++) begin
			v = $random(seed);
			wr(OFS_CUTOFF, 32'(k) << 4);
			pwm_wave_i <= v[1:0];
			wait2();
			for (j = 0; j < 2; j++) begin
				cd = (j == 0) ? 2'(k >> 2) : 2'(k);
				check("pin_float", flt[j], cd == 2'h1);
				if (cd != 2'h1) begin
					check("pin_level", pad[j], (cd == 2'h0) ? v[j] : cd[0]);
				end
			end
		end
		// Unused cutoffs go back to disabled before anything else.
		wr(OFS_CUTOFF, 32'h0);
		wr(OFS_CLK_EN, 32'h0);
		rd(OFS_MODE, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire

/* rspwm_pkg.sv */
// Shared constants and types of the reset-synchronous PWM timer setup block.
package rspwm_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses, one aligned word each.
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h00;
	localparam logic [7:0] OFS_IRQ_REQ   = 8'h04;
	localparam logic [7:0] OFS_PRIO_LO   = 8'h08;
	localparam logic [7:0] OFS_PRIO_HI   = 8'h0c;
	localparam logic [7:0] OFS_MODE      = 8'h10;
	localparam logic [7:0] OFS_FUNC_CTRL = 8'h14;
	localparam logic [7:0] OFS_CUTOFF    = 8'h18;
	localparam logic [7:0] OFS_CLK_EN    = 8'h1c;
	// Compare registers: base + 16 * counter + 4 * (A, B, C, D).
	localparam logic [2:0] OFS_CMP_PAGE  = 3'h1;

	// Field positions.
	localparam int CH0_IRQ_BIT     = 1;
	localparam int CNT1_D_BUF_BIT  = 7;
	localparam int CNT1_C_BUF_BIT  = 6;
	localparam int CNT0_D_BUF_BIT  = 5;
	localparam int CNT0_C_BUF_BIT  = 4;
	localparam int LOCKSTEP_BIT    = 0;
	localparam int COUNTER_LVL_BIT = 3;
	localparam int NORMAL_LVL_BIT  = 2;
	localparam int COMB_MODE_LSB   = 0;
	localparam int PIN_A_CUT_LSB   = 6;
	localparam int PIN_B_CUT_LSB   = 4;

	// Writable bits; the others read as zero.
	localparam logic [7:0] MODE_WMASK = 8'hf1;
	localparam logic [7:0] FCR_WMASK  = 8'hcf;

	// Reset values.
	localparam logic [7:0]  RST_IRQ_MASK = 8'hff;
	localparam logic [7:0]  RST_IRQ_REQ  = 8'h00;
	localparam logic [7:0]  RST_PRIO     = 8'hff;
	localparam logic [7:0]  RST_MODE     = 8'h00;
	localparam logic [7:0]  RST_FCR      = 8'h00;
	localparam logic [7:0]  RST_CUTOFF   = 8'h00;
	localparam logic [15:0] RST_CMP      = 16'hffff;

	// Combination mode codes.
	localparam logic [1:0] CMB_TIMER     = 2'h0;
	localparam logic [1:0] CMB_RESET_PWM = 2'h1;
	localparam logic [1:0] CMB_COMP_UF   = 2'h2;
	localparam logic [1:0] CMB_COMP_MA   = 2'h3;

	// Forced cutoff codes.
	localparam logic [1:0] CUT_OFF   = 2'h0;
	localparam logic [1:0] CUT_FLOAT = 2'h1;
	localparam logic [1:0] CUT_LOW   = 2'h2;
	localparam logic [1:0] CUT_HIGH  = 2'h3;

	// One counter's four compare registers.
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic [15:0] d;
	} rspwm_cmp_t;

	// Counter events from the counting logic.
	typedef struct packed {
		logic cnt0_match_a;
		logic cnt1_match_a;
		logic cnt1_underflow;
		logic ch0_timer_interrupt;
	} rspwm_ev_t;

	// Levels for the waveform generator.
	typedef struct packed {
		logic en;
		logic normal_active;
		logic counter_active;
	} rspwm_phase_t;

	// One output pin: level and output enable.
	typedef struct packed {
		logic dout;
		logic oe;
	} rspwm_pin_t;

endpackage

/* rspwm_setup.sv */
// Register file, interrupt and output cutoff of the PWM timer setup block.
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module rspwm_setup (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic [rspwm_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                        avs_read_i,
	input  wire logic                        avs_write_i,
	input  wire logic [rspwm_pkg::DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]                  avs_byteenable_i,
	output logic      [rspwm_pkg::DATA_W-1:0] avs_readdata_o,
	output logic                             avs_waitrequest_o,
	input  wire rspwm_pkg::rspwm_ev_t        events_i,
	input  wire logic [1:0]                  pwm_wave_i,
	input  wire logic                        cutoff_req_i,
	output logic                             irq_o,
	output logic      [1:0]                  irq_level_o,
	output logic                             lockstep_o,
	output logic      [1:0]                  comb_mode_o,
	output rspwm_pkg::rspwm_phase_t          phase_o,
	output rspwm_pkg::rspwm_cmp_t            cnt0_cmp_o,
	output rspwm_pkg::rspwm_cmp_t            cnt1_cmp_o,
	output rspwm_pkg::rspwm_pin_t            ch0_pin_a_o,
	output rspwm_pkg::rspwm_pin_t            ch0_pin_b_o
);
	import rspwm_pkg::*;

	logic [7:0]  mask_q;
	logic [7:0]  req_q;
	logic [7:0]  req_d;
	logic [7:0]  prio_lo_q;
	logic [7:0]  prio_hi_q;
	logic [7:0]  mode_q;
	logic [7:0]  fcr_q;
	logic [7:0]  cutoff_q;
	logic        clk_en_q;
	logic        wait_q;
	logic        acc;
	logic        wr;
	logic        rd;
	logic [31:0] rd_d;
	logic [1:0]  xfer;
	logic [1:0]  cmb;
	rspwm_cmp_t  cmp_q [2];

	// One wait cycle on every access gives time to register read data.
	assign acc = (avs_read_i | avs_write_i) & ~wait_q;
	assign wr  = acc & avs_write_i;
	assign rd  = acc & avs_read_i;
	assign cmb = fcr_q[COMB_MODE_LSB +: 2];

	// Byte-lane merge of one 16-bit compare register.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Wait state toggles low for exactly the completing cycle.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
		end
	end

	// Read data is captured in the first cycle and stands for the second.
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (avs_address_i)
			OFS_IRQ_MASK:  rd_d[7:0] = mask_q;
			OFS_IRQ_REQ:   rd_d[7:0] = req_q;
			OFS_PRIO_LO:   rd_d[7:0] = prio_lo_q;
			OFS_PRIO_HI:   rd_d[7:0] = prio_hi_q;
			OFS_MODE:      rd_d[7:0] = mode_q;
			OFS_FUNC_CTRL: rd_d[7:0] = fcr_q;
			OFS_CUTOFF:    rd_d[7:0] = cutoff_q;
			OFS_CLK_EN:    rd_d[0]   = clk_en_q;
			default: begin
				if (avs_address_i[7:5] == OFS_CMP_PAGE &&
					avs_address_i[1:0] == 2'h0) begin
					unique case (avs_address_i[3:2])
						2'h0: rd_d[15:0] = cmp_q[avs_address_i[4]].a;
						2'h1: rd_d[15:0] = cmp_q[avs_address_i[4]].b;
						2'h2: rd_d[15:0] = cmp_q[avs_address_i[4]].c;
						2'h3: rd_d[15:0] = cmp_q[avs_address_i[4]].d;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && wait_q) begin
			avs_readdata_o <= rd_d;
		end
	end

	// Interrupt controller registers stay alive while the timer is gated.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_q    <= RST_IRQ_MASK;
			prio_lo_q <= RST_PRIO;
			prio_hi_q <= RST_PRIO;
			clk_en_q  <= 1'b0;
		end else if (wr && avs_byteenable_i[0]) begin
			unique case (avs_address_i)
				OFS_IRQ_MASK: mask_q    <= avs_writedata_i[7:0];
				OFS_PRIO_LO:  prio_lo_q <= avs_writedata_i[7:0];
				OFS_PRIO_HI:  prio_hi_q <= avs_writedata_i[7:0];
				OFS_CLK_EN:   clk_en_q  <= avs_writedata_i[0];
				default: begin
				end
			endcase
		end
	end

	// Request flags: a completed read or a write of 0 clears them.
	always_comb begin
		req_d = req_q;
		if (acc && avs_address_i == OFS_IRQ_REQ) begin
			if (rd) begin
				req_d = 8'h00;
			end else if (avs_byteenable_i[0]) begin
				req_d = req_q & avs_writedata_i[7:0];
			end
		end
		// The set wins over a clear in one cycle, so no event is lost.
		if (events_i.ch0_timer_interrupt) begin
			req_d[CH0_IRQ_BIT] = 1'b1;
		end
	end

	// The flag register itself.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_q <= RST_IRQ_REQ;
		end else begin
			req_q <= req_d;
		end
	end

	// Interrupt line follows one cycle behind the flags, level one cycle behind the priority bits.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o       <= 1'b0;
			irq_level_o <= 2'h3;
		end else begin
			irq_o <= req_q[CH0_IRQ_BIT] & ~mask_q[CH0_IRQ_BIT];
			irq_level_o <= {prio_hi_q[CH0_IRQ_BIT],
				prio_lo_q[CH0_IRQ_BIT]};
		end
	end

	// Timer registers: cleared and write-protected while the clock is off.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q   <= RST_MODE;
			fcr_q    <= RST_FCR;
			cutoff_q <= RST_CUTOFF;
		end else if (!clk_en_q) begin
			mode_q   <= RST_MODE;
			fcr_q    <= RST_FCR;
			cutoff_q <= RST_CUTOFF;
		end else if (wr && avs_byteenable_i[0]) begin
			unique case (avs_address_i)
				OFS_MODE:      mode_q   <= avs_writedata_i[7:0] & MODE_WMASK;
				OFS_FUNC_CTRL: fcr_q    <= avs_writedata_i[7:0] & FCR_WMASK;
				OFS_CUTOFF:    cutoff_q <= avs_writedata_i[7:0];
				default: begin
				end
			endcase
		end
	end

	// Buffer transfer moments depend on the combination mode.
	always_comb begin
		unique case (cmb)
			CMB_TIMER: xfer = {events_i.cnt1_match_a,
				events_i.cnt0_match_a};
			CMB_RESET_PWM: xfer = {2{events_i.cnt0_match_a}};
			CMB_COMP_UF:   xfer = {2{events_i.cnt1_underflow}};
			CMB_COMP_MA:   xfer = {2{events_i.cnt0_match_a}};
		endcase
	end

	// Compare registers per counter; a transfer beats a bus write to A/B.
	for (genvar k = 0; k < 2; k++) begin : g_cnt
		logic buf_c;
		logic buf_d;
		logic hit;
		// Counter 0 uses bits 4/5, counter 1 bits 6/7.
		assign buf_c = mode_q[CNT0_C_BUF_BIT + 2 * k];
		assign buf_d = mode_q[CNT0_D_BUF_BIT + 2 * k];
		assign hit = wr && clk_en_q && avs_address_i[7:5] == OFS_CMP_PAGE
			&& avs_address_i[4] == 1'(k) && avs_address_i[1:0] == 2'h0;
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cmp_q[k] <= {4{RST_CMP}};
			end else if (!clk_en_q) begin
				cmp_q[k] <= {4{RST_CMP}};
			end else begin
				if (hit) begin
					unique case (avs_address_i[3:2])
						2'h0: cmp_q[k].a <= merge16(cmp_q[k].a,
							avs_writedata_i, avs_byteenable_i);
						2'h1: cmp_q[k].b <= merge16(cmp_q[k].b,
							avs_writedata_i, avs_byteenable_i);
						2'h2: cmp_q[k].c <= merge16(cmp_q[k].c,
							avs_writedata_i, avs_byteenable_i);
						2'h3: cmp_q[k].d <= merge16(cmp_q[k].d,
							avs_writedata_i, avs_byteenable_i);
					endcase
				end
				if (xfer[k] && buf_c) begin
					cmp_q[k].a <= cmp_q[k].c;
				end
				if (xfer[k] && buf_d) begin
					cmp_q[k].b <= cmp_q[k].d;
				end
			end
		end
	end

	assign cnt0_cmp_o = cmp_q[0];
	assign cnt1_cmp_o = cmp_q[1];

	// Mode outputs toward the counting and waveform logic.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lockstep_o  <= 1'b0;
			comb_mode_o <= CMB_TIMER;
			phase_o     <= '0;
		end else begin
			lockstep_o  <= mode_q[LOCKSTEP_BIT];
			comb_mode_o <= cmb;
			// Levels only mean something in the three modes other than timer mode.
			phase_o.en <= (cmb != CMB_TIMER);
			phase_o.normal_active <= (cmb != CMB_TIMER) &&
				fcr_q[NORMAL_LVL_BIT];
			phase_o.counter_active <= (cmb != CMB_TIMER) &&
				fcr_q[COUNTER_LVL_BIT];
		end
	end

	// Forced cutoff per pin; pins float while the clock is off.
	for (genvar p = 0; p < 2; p++) begin : g_pin
		logic [1:0] fld;
		rspwm_pin_t pin_q;
		assign fld = (p == 0) ? cutoff_q[PIN_A_CUT_LSB +: 2]
			: cutoff_q[PIN_B_CUT_LSB +: 2];
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				pin_q <= '0;
			end else if (!clk_en_q) begin
				pin_q <= '0;
			end else if (!cutoff_req_i || fld == CUT_OFF) begin
				pin_q <= '{dout: pwm_wave_i[p], oe: 1'b1};
			end else begin
				unique case (fld)
					CUT_FLOAT: pin_q <= '{dout: 1'b0, oe: 1'b0};
					CUT_LOW:   pin_q <= '{dout: 1'b0, oe: 1'b1};
					default:   pin_q <= '{dout: 1'b1, oe: 1'b1};
				endcase
			end
		end
	end

	assign ch0_pin_a_o = g_pin[0].pin_q;
	assign ch0_pin_b_o = g_pin[1].pin_q;

	// Waitrequest is the wait flop itself.
	assign avs_waitrequest_o = wait_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	mask_blocks_a: assert property (mask_q[1] |=> !irq_o)
		else $error("masked request reached the interrupt line");
	flag_clear_a: assert property (wr && avs_address_i == OFS_IRQ_REQ &&
		avs_byteenable_i[0] && !avs_writedata_i[1] &&
		!events_i.ch0_timer_interrupt |=> !req_q[1])
		else $error("write of 0 left the request flag set");
	prio_level_a: assert property (##1 irq_level_o ==
		{$past(prio_hi_q[1]), $past(prio_lo_q[1])})
		else $error("priority level does not match the two bits");
	buf_cnt1_a: assert property (clk_en_q && xfer[1] && mode_q[7]
		|=> cmp_q[1].b == $past(cmp_q[1].d))
		else $error("counter 1 D did not load B");
	buf_cnt0_a: assert property (clk_en_q && xfer[0] && mode_q[4]
		|=> cmp_q[0].a == $past(cmp_q[0].c))
		else $error("counter 0 C did not load A");
	general_reg_a: assert property (clk_en_q && !mode_q[6] && !wr
		|=> $stable(cmp_q[1].a))
		else $error("general register A changed without a write");
	lockstep_out_a: assert property (mode_q[0] ##1 mode_q[0] |-> lockstep_o)
		else $error("lockstep output not following mode bit");
	timer_levels_a: assert property (cmb == CMB_TIMER |=> !phase_o.en &&
		!phase_o.normal_active && !phase_o.counter_active)
		else $error("phase levels active in timer mode");
	comp_uf_a: assert property (cmb == CMB_COMP_UF &&
		events_i.cnt1_underflow |-> xfer == 2'h3)
		else $error("underflow did not trigger buffer transfer");
	cut_float_a: assert property (clk_en_q && cutoff_req_i &&
		cutoff_q[7:6] == CUT_FLOAT |=> !ch0_pin_a_o.oe)
		else $error("pin A still driven in float cutoff");
	cut_high_a: assert property (clk_en_q && cutoff_req_i &&
		cutoff_q[5:4] == CUT_HIGH |=> ch0_pin_b_o.oe && ch0_pin_b_o.dout)
		else $error("pin B not driven high in cutoff");
	gated_regs_a: assert property (!clk_en_q |=> mode_q == RST_MODE &&
		fcr_q == RST_FCR)
		else $error("timer registers kept state with clock off");
	flag_set_a: assert property (events_i.ch0_timer_interrupt |=> req_q[1])
		else $error("event did not set the request flag");
	unmask_raise_a: assert property (req_q[1] && !mask_q[1] |=> irq_o)
		else $error("pending unmasked request not raised");

	// Further guards on the bus handshake, buffers, levels and pins.
	// The wait state must last exactly one cycle, so a master never hangs.
	wait_one_a: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("access got no completing cycle");
	wait_back_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest stayed low two cycles");
	buf_d0_a: assert property (clk_en_q && xfer[0] && mode_q[5]
		|=> cmp_q[0].b == $past(cmp_q[0].d))
		else $error("counter 0 D did not load B");
	buf_c1_a: assert property (clk_en_q && xfer[1] && mode_q[6]
		|=> cmp_q[1].a == $past(cmp_q[1].c))
		else $error("counter 1 C did not load A");
	general_b0_a: assert property (clk_en_q && !mode_q[5] && !wr
		|=> $stable(cmp_q[0].b))
		else $error("general register B changed without a write");
	normal_level_a: assert property (cmb != CMB_TIMER
		|=> phase_o.normal_active == $past(fcr_q[2]))
		else $error("normal-phase level does not follow its bit");
	counter_level_a: assert property (cmb != CMB_TIMER
		|=> phase_o.counter_active == $past(fcr_q[3]))
		else $error("counter-phase level does not follow its bit");
	comb_out_a: assert property (##1 comb_mode_o == $past(cmb))
		else $error("combination mode output does not follow field");
	reset_pwm_xfer_a: assert property (cmb == CMB_RESET_PWM
		|-> xfer == {2{events_i.cnt0_match_a}})
		else $error("reset PWM transfer not on counter 0 match");
	cut_low_a: assert property (clk_en_q && cutoff_req_i &&
		cutoff_q[7:6] == CUT_LOW |=> ch0_pin_a_o.oe && !ch0_pin_a_o.dout)
		else $error("pin A not driven low in cutoff");
	cut_pass_a: assert property (clk_en_q && (!cutoff_req_i ||
		cutoff_q[5:4] == CUT_OFF) |=> ch0_pin_b_o.oe &&
		ch0_pin_b_o.dout == $past(pwm_wave_i[1]))
		else $error("pin B does not follow the waveform");
	read_clear_a: assert property (rd && avs_address_i == OFS_IRQ_REQ &&
		!events_i.ch0_timer_interrupt |=> !req_q[1])
		else $error("read of the request register left the flag set");
	gated_pins_a: assert property (!clk_en_q |=> cutoff_q == RST_CUTOFF &&
		!ch0_pin_a_o.oe && !ch0_pin_b_o.oe)
		else $error("pins or cutoff active with clock off");
	level_hold_a: assert property ($stable(prio_hi_q) && $stable(prio_lo_q)
		|=> $stable(irq_level_o))
		else $error("priority level moved with fixed priority bits");

endmodule
`default_nettype wire

/* rspwm_stage.sv */
// Power stage model that resolves the two channel-0 pins to pad levels.
`timescale 1ns/10ps
`default_nettype none
module rspwm_stage (
	input  wire logic                  clk_sys_i,
	input  wire rspwm_pkg::rspwm_pin_t pin_a_i,
	input  wire rspwm_pkg::rspwm_pin_t pin_b_i,
	output logic [1:0]                 pad_o,
	output logic [1:0]                 float_o
);
	import rspwm_pkg::*;
	logic [1:0] last_q;

	// A released pad has no pull, so it shows the inverse of its last level.
	always_ff @(posedge clk_sys_i) begin
		last_q <= pad_o;
	end

	// Pads follow the pins only while driven; a float shows up as a flag.
	assign pad_o   = {pin_b_i.oe ? pin_b_i.dout : ~last_q[1],
	                  pin_a_i.oe ? pin_a_i.dout : ~last_q[0]};
	assign float_o = {~pin_b_i.oe, ~pin_a_i.oe};
endmodule
`default_nettype wire
